// ---- rtl/ipa_pkg.sv ----
// constants of the interrupt priority arbiter: register map, field positions, reset values
// assumes an avalon-mm slave port with byte addresses and 32-bit data
package ipa_pkg;
    localparam logic [11:0] OFS_MASK = 12'h000;
    localparam logic [11:0] OFS_BINPT = 12'h004;
    localparam logic [11:0] OFS_RUNPRIO = 12'h008;
    localparam logic [11:0] OFS_HIPEND = 12'h00c;
    localparam logic [11:0] OFS_ACTIVE = 12'h010;
    localparam logic [11:0] OFS_PREEMPT = 12'h014;
    localparam logic [3:0] PRIO_REGION = 4'h1;
    localparam logic [7:0] PRIO_FIELD_ONES = 8'hff;
    localparam logic [7:0] RUN_IDLE = 8'hff;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] GROUP_BASE_MASK = 8'hfe;
    localparam int HIPEND_VALID_BIT = 31;
    localparam int HIPEND_ID_LSB = 8;
    localparam int PRIO_W = 8;
    localparam int PRIO_BITS_MIN = 4;
    localparam int PRIO_BITS_MAX = 8;
endpackage : ipa_pkg

// ---- rtl/ipa_arbiter.sv ----
// interrupt priority arbiter: priorities, mask, binary point, running priority, selection
// assumes pending levels, acknowledge, drop and deactivate pulses synchronous to clock
`timescale 1ns/1ps
module ipa_arbiter #(
    parameter int N_IRQ = 8,
    parameter int PRIO_BITS = 5,
    parameter logic [2:0] MIN_BPR = 3'h0,
    parameter logic [N_IRQ-1:0] FIXED_IRQ_MASK = '0,
    parameter logic [7:0] FIXED_PRIO = 8'h00
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // avalon-mm slave
    input wire logic [11:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // interrupt sources
    input wire logic [N_IRQ-1:0] irq_pending,
    // processor side
    output logic irq_signal,
    input wire logic cpu_ack,
    output logic [$clog2(N_IRQ)-1:0] ack_id,
    output logic ack_valid,
    output logic ack_spurious,
    input wire logic prio_drop,
    input wire logic [$clog2(N_IRQ)-1:0] drop_id,
    input wire logic deactivate,
    input wire logic [$clog2(N_IRQ)-1:0] deact_id
);
    localparam int ID_W = $clog2(N_IRQ);
    // unbuilt low bits are held zero by this mask everywhere a field is stored
    localparam logic [7:0] IMPL_MASK = 8'(ipa_pkg::PRIO_FIELD_ONES << (8 - PRIO_BITS));

    typedef struct packed {
        logic [N_IRQ-1:0][7:0] prio;
        logic [7:0] pmr;
        logic [2:0] bpr;
        logic [N_IRQ-1:0] active;
        logic [N_IRQ-1:0] dropped;
        logic [N_IRQ-1:0] preempted;
        logic bus_ack;
        logic [31:0] rdata;
        logic [ID_W-1:0] ack_id;
        logic ack_valid;
        logic ack_spurious;
    } ipa_state_t;

    ipa_state_t st_r;
    ipa_state_t st_nxt;

    logic [7:0] grp_mask;
    logic found;
    logic [ID_W-1:0] best_id;
    logic [7:0] best_prio;
    logic any_run;
    logic [7:0] run_prio;
    logic irq_ok;
    logic [ID_W-1:0] widx;
    logic widx_ok;
    logic [7:0] wbyte;
    logic [2:0] bp_in;

    always_comb begin
        // bp 0..6 keeps bits 7..bp+1 as group; bp 7 shifts everything out
        grp_mask = 8'(ipa_pkg::GROUP_BASE_MASK << st_r.bpr);
        found = 1'b0;
        best_id = '0;
        best_prio = ipa_pkg::PRIO_FIELD_ONES;
        any_run = 1'b0;
        run_prio = ipa_pkg::RUN_IDLE;
        for (int i = 0; i < N_IRQ; i++) begin
            // full-value compare orders group then subpriority; strict < keeps lowest id
            if (irq_pending[i] && !st_r.active[i] && (!found || st_r.prio[i] < best_prio)) begin
                found = 1'b1;
                best_id = ID_W'(i);
                best_prio = st_r.prio[i];
            end
            if (st_r.active[i] && !st_r.dropped[i]) begin
                any_run = 1'b1;
                if ((st_r.prio[i] & grp_mask) < run_prio) begin
                    run_prio = st_r.prio[i] & grp_mask;
                end
            end
        end
        irq_ok = found
            && best_prio < st_r.pmr
            && best_prio != IMPL_MASK
            && (!any_run || (best_prio & grp_mask) < run_prio);
    end

    // bus decode shared by read and write
    always_comb begin
        widx = ID_W'(avs_address[7:2]);
        widx_ok = (avs_address[11:8] == ipa_pkg::PRIO_REGION) && (avs_address[1:0] == 2'h0)
            && (32'(avs_address[7:2]) < N_IRQ);
        wbyte = avs_writedata[7:0];
        bp_in = (avs_writedata[2:0] < MIN_BPR) ? MIN_BPR : avs_writedata[2:0];
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.ack_valid = 1'b0;
        st_nxt.ack_spurious = 1'b0;
        // every request waits exactly one cycle so read data come from a flop
        st_nxt.bus_ack = (avs_read || avs_write) && !st_r.bus_ack;
        if (avs_read && !st_r.bus_ack) begin
            st_nxt.rdata = 32'h0;
            if (widx_ok) begin
                st_nxt.rdata[7:0] = st_r.prio[widx];
            end else begin
                case (avs_address)
                    ipa_pkg::OFS_MASK: st_nxt.rdata[7:0] = st_r.pmr;
                    ipa_pkg::OFS_BINPT: st_nxt.rdata[2:0] = st_r.bpr;
                    ipa_pkg::OFS_RUNPRIO: st_nxt.rdata[7:0] = run_prio;
                    ipa_pkg::OFS_HIPEND: begin
                        st_nxt.rdata[ipa_pkg::HIPEND_VALID_BIT] = found;
                        st_nxt.rdata[ipa_pkg::HIPEND_ID_LSB +: 8] = 8'(best_id);
                        st_nxt.rdata[7:0] = best_prio;
                    end
                    ipa_pkg::OFS_ACTIVE: st_nxt.rdata = 32'(st_r.active);
                    ipa_pkg::OFS_PREEMPT: st_nxt.rdata = 32'(st_r.preempted);
                    default: st_nxt.rdata = 32'h0;
                endcase
            end
        end
        if (avs_write && st_r.bus_ack && avs_byteenable[0]) begin
            if (widx_ok) begin
                // a fixed source keeps its wired value
                if (!FIXED_IRQ_MASK[widx]) begin
                    st_nxt.prio[widx] = wbyte & IMPL_MASK;
                end
            end else begin
                case (avs_address)
                    ipa_pkg::OFS_MASK: st_nxt.pmr = wbyte & IMPL_MASK;
                    ipa_pkg::OFS_BINPT: st_nxt.bpr = bp_in;
                    default: st_nxt.bpr = st_r.bpr;
                endcase
            end
        end
        // fixed priorities are forced here too, so no path can disturb them
        for (int i = 0; i < N_IRQ; i++) begin
            if (FIXED_IRQ_MASK[i]) begin
                st_nxt.prio[i] = FIXED_PRIO & IMPL_MASK;
            end
        end
        if (prio_drop && st_r.active[drop_id]) begin
            st_nxt.dropped[drop_id] = 1'b1;
        end
        // deactivation first, so an acknowledge in the same cycle is not undone
        if (deactivate) begin
            st_nxt.active[deact_id] = 1'b0;
            st_nxt.dropped[deact_id] = 1'b0;
            st_nxt.preempted[deact_id] = 1'b0;
        end
        if (cpu_ack) begin
            st_nxt.ack_valid = 1'b1;
            if (irq_ok) begin
                // the older running ones stay active but are now preempted
                st_nxt.preempted = st_nxt.preempted | (st_r.active & ~st_r.dropped);
                st_nxt.active[best_id] = 1'b1;
                st_nxt.ack_id = best_id;
            end else begin
                st_nxt.ack_spurious = 1'b1;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_r <= '0;
            st_r.pmr <= ipa_pkg::MASK_RESET;
            st_r.bpr <= MIN_BPR;
            // wired priorities are valid from reset on, not only after the first edge
            for (int i = 0; i < N_IRQ; i++) begin
                if (FIXED_IRQ_MASK[i]) begin
                    st_r.prio[i] <= FIXED_PRIO & IMPL_MASK;
                end
            end
        end else begin
            st_r <= st_nxt;
        end
    end

    assign avs_waitrequest = (avs_read || avs_write) && !st_r.bus_ack;
    assign avs_readdata = st_r.rdata;
    assign irq_signal = irq_ok;
    assign ack_id = st_r.ack_id;
    assign ack_valid = st_r.ack_valid;
    assign ack_spurious = st_r.ack_spurious;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence s_wr_ff(logic [11:0] ofs);
        avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address == ofs
            && avs_writedata[7:0] == 8'hff;
    endsequence

    sequence s_ack_good;
        cpu_ack && irq_signal;
    endsequence

    sequence s_wr_any(logic [11:0] ofs);
        avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address == ofs;
    endsequence

    sequence s_rd_req(logic [11:0] ofs);
        avs_read && avs_waitrequest && avs_address == ofs;
    endsequence

    a_mask_zero_blocks: assert property (st_r.pmr == 8'h00 |-> !irq_signal)
        else $error("interrupt signalled with zero mask");

    a_mask_strict_cmp: assert property (irq_signal |-> best_prio < st_r.pmr)
        else $error("signalled priority not below mask");

    a_max_prio_masked: assert property (irq_signal |-> best_prio != IMPL_MASK)
        else $error("largest priority value signalled");

    a_preempt_group_lt: assert property (irq_signal && any_run
            |-> (best_prio & grp_mask) < run_prio)
        else $error("preemption without lower group value");

    a_mask_255_store: assert property (s_wr_ff(ipa_pkg::OFS_MASK)
            |=> st_r.pmr == IMPL_MASK)
        else $error("mask write of 255 not stored as largest value");

    a_probe_width_read: assert property (s_wr_ff(12'h100) && !FIXED_IRQ_MASK[0]
            |=> st_r.prio[0] == IMPL_MASK)
        else $error("priority probe did not leave implemented ones");

    a_fixed_prio_held: assert property (FIXED_IRQ_MASK[0] |-> st_r.prio[0]
            == (FIXED_PRIO & IMPL_MASK))
        else $error("fixed priority changed");

    a_ack_marks_active: assert property (s_ack_good ##0 (!deactivate)
            |=> ack_valid && !ack_spurious && st_r.active[ack_id])
        else $error("acknowledge did not activate the selected source");

    a_drop_frees_run: assert property (prio_drop && st_r.active[drop_id]
            && !deactivate && !cpu_ack && $onehot(st_r.active)
            |=> !any_run ##0 run_prio == 8'hff)
        else $error("dropped source still holds running priority");

    a_bus_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest
            |=> !avs_waitrequest)
        else $error("bus answer later than one wait cycle");

    a_bpr_floor_kept: assert property (st_r.bpr >= MIN_BPR)
        else $error("binary point below the smallest accepted value");

    a_pmr_unbuilt_zero: assert property ((st_r.pmr & ~IMPL_MASK) == 8'h00)
        else $error("unbuilt mask bit set");

    a_mask_reset_zero: assert property ($fell(rst)
            |-> st_r.pmr == ipa_pkg::MASK_RESET)
        else $error("mask threshold not zero after reset");

    a_run_idle_value: assert property (!any_run |-> run_prio == ipa_pkg::RUN_IDLE)
        else $error("running priority not idle with nothing running");

    a_idle_signals: assert property (!any_run && found && best_prio < st_r.pmr
            && best_prio != IMPL_MASK |-> irq_signal)
        else $error("unmasked source not signalled while idle");

    a_equal_group_held: assert property (any_run
            && (best_prio & grp_mask) == run_prio |-> !irq_signal)
        else $error("equal group priority preempted");

    a_bp7_no_preempt: assert property (st_r.bpr == 3'h7 && any_run |-> !irq_signal)
        else $error("preemption with binary point seven");

    a_group_split: assert property (st_r.bpr != 3'h7
            |-> grp_mask[7] && !grp_mask[st_r.bpr])
        else $error("binary point bit not in the subpriority");

    a_bpr_write_store: assert property (s_wr_any(ipa_pkg::OFS_BINPT)
            ##0 (avs_writedata[2:0] >= MIN_BPR) |=> st_r.bpr == $past(avs_writedata[2:0]))
        else $error("binary point write not stored");

    a_prio_write_store: assert property (s_wr_any(12'h104) ##0 (!FIXED_IRQ_MASK[1])
            |=> st_r.prio[1] == ($past(avs_writedata[7:0]) & IMPL_MASK))
        else $error("priority write not stored in built bits");

    a_mask_write_store: assert property (s_wr_any(ipa_pkg::OFS_MASK)
            |=> st_r.pmr == ($past(avs_writedata[7:0]) & IMPL_MASK))
        else $error("mask write not stored in built bits");

    a_signal_needs_pend: assert property (irq_signal |-> found)
        else $error("signal without a pending source");

    a_mask_blocks_ge: assert property (found && best_prio >= st_r.pmr |-> !irq_signal)
        else $error("source at or above mask signalled");

    a_spurious_ack: assert property (cpu_ack && !irq_signal
            |=> ack_valid && ack_spurious)
        else $error("acknowledge without signal not spurious");

    a_good_ack_clean: assert property (s_ack_good |=> !ack_spurious)
        else $error("qualified acknowledge reported spurious");

    a_ack_valid_pulse: assert property (ack_valid |-> $past(cpu_ack))
        else $error("acknowledge answer without acknowledge");

    // the running ones at the acknowledge must all carry the preempted mark after it
    a_preempt_marked: assert property (s_ack_good ##0 (!deactivate) |=>
            (st_r.preempted & $past(st_r.active & ~st_r.dropped))
            == $past(st_r.active & ~st_r.dropped))
        else $error("running source not marked preempted");

    a_active_kept: assert property (s_ack_good ##0 (!deactivate)
            |=> (st_r.active & $past(st_r.active)) == $past(st_r.active))
        else $error("older active source lost at acknowledge");

    a_ack_id_held: assert property (!(cpu_ack && irq_signal) |=> $stable(ack_id))
        else $error("granted id changed without acknowledge");

    a_drop_needs_active: assert property (prio_drop && !st_r.active[drop_id]
            && !deactivate |=> st_r.dropped == $past(st_r.dropped))
        else $error("drop of an inactive source took effect");

    a_deact_clears: assert property (deactivate && !cpu_ack
            |=> !st_r.active[$past(deact_id)] && !st_r.dropped[$past(deact_id)])
        else $error("deactivate left the source active");

    a_run_read: assert property (s_rd_req(ipa_pkg::OFS_RUNPRIO)
            |=> avs_readdata[7:0] == $past(run_prio))
        else $error("running priority read back wrong");

    a_mask_read: assert property (s_rd_req(ipa_pkg::OFS_MASK)
            |=> avs_readdata[7:0] == $past(st_r.pmr))
        else $error("mask read back wrong");

    a_bp_read: assert property (s_rd_req(ipa_pkg::OFS_BINPT)
            |=> avs_readdata[2:0] == $past(st_r.bpr))
        else $error("binary point read back wrong");

    a_hipend_read: assert property (s_rd_req(ipa_pkg::OFS_HIPEND)
            |=> avs_readdata[7:0] == $past(best_prio) && avs_readdata[31] == $past(found))
        else $error("highest pending read back wrong");

    a_active_read: assert property (s_rd_req(ipa_pkg::OFS_ACTIVE)
            |=> avs_readdata[N_IRQ-1:0] == $past(st_r.active))
        else $error("active bits read back wrong");

    a_preempt_read: assert property (s_rd_req(ipa_pkg::OFS_PREEMPT)
            |=> avs_readdata[N_IRQ-1:0] == $past(st_r.preempted))
        else $error("preempted bits read back wrong");

    a_prio_read: assert property (avs_read && avs_waitrequest && widx_ok
            |=> avs_readdata[7:0] == $past(st_r.prio[widx]))
        else $error("priority read back wrong");

    // per-source checks of selection, running value and wired priorities
    for (genvar g = 0; g < N_IRQ; g++) begin : g_src_chk
        a_unbuilt_zero: assert property ((st_r.prio[g] & ~IMPL_MASK) == 8'h00)
            else $error("unbuilt priority bit set");

        a_best_is_min: assert property (irq_pending[g] && !st_r.active[g]
                |-> found && best_prio <= st_r.prio[g])
            else $error("a more urgent pending source was passed over");

        a_tie_low_id: assert property (irq_pending[g] && !st_r.active[g]
                && st_r.prio[g] == best_prio |-> best_id <= ID_W'(g))
            else $error("equal priority not resolved to the lowest id");

        a_run_is_min: assert property (st_r.active[g] && !st_r.dropped[g]
                |-> run_prio <= (st_r.prio[g] & grp_mask))
            else $error("running priority above an undropped active source");

        a_fixed_src_held: assert property (FIXED_IRQ_MASK[g]
                |-> st_r.prio[g] == (FIXED_PRIO & IMPL_MASK))
            else $error("wired priority changed");
    end : g_src_chk
endmodule : ipa_arbiter

// ---- verification/ipa_cpu_model.sv ----
// processor model: acknowledges a signalled interrupt while enabled
// assumes ack_valid answers every cpu_ack one cycle later
`timescale 1ns/1ps
module ipa_cpu_model (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // handshake
    input wire logic en,
    input wire logic irq_signal,
    input wire logic ack_valid,
    output logic cpu_ack
);
    logic busy_r;
    // one ack in flight, so a stale signal is never taken twice
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cpu_ack <= 1'b0;
            busy_r <= 1'b0;
        end else begin
            cpu_ack <= en && irq_signal && !busy_r && !cpu_ack;
            busy_r <= (busy_r || cpu_ack) && !ack_valid;
        end
    end
endmodule : ipa_cpu_model

// ---- verification/interrupt_priority_arbiter_tb.sv ----
// bench of the priority arbiter: fields, mask, grouping, preemption
// assumes the avalon slave answers after a wait and the cpu model acks
`timescale 1ns/1ps
module interrupt_priority_arbiter_tb;
    localparam int PB = 5;
    logic clock = 0;
    logic rst = 1;
    logic [11:0] avs_address = '0;
    logic avs_read = 0;
    logic avs_write = 0;
    logic [31:0] avs_writedata = '0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, irq_signal, cpu_ack, ack_valid, ack_spurious;
    logic en = 0;
    logic prio_drop = 0;
    logic deactivate = 0;
    logic [7:0] irq_pending = '0;
    logic [7:0] d, v;
    logic [2:0] ack_id;
    logic [2:0] drop_id = '0;
    logic [2:0] deact_id = '0;
    int n_errors = 0;
    int samples_checked = 0;
    int k;
    ipa_arbiter #(.N_IRQ(8), .PRIO_BITS(PB), .MIN_BPR(3'h0), .FIXED_IRQ_MASK(8'h80),
        .FIXED_PRIO(8'h10)) ipa_arbiter_inst (.clock(clock), .rst(rst),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .irq_pending(irq_pending), .irq_signal(irq_signal),
        .cpu_ack(cpu_ack), .ack_id(ack_id), .ack_valid(ack_valid), .ack_spurious(ack_spurious),
        .prio_drop(prio_drop), .drop_id(drop_id), .deactivate(deactivate), .deact_id(deact_id));
    ipa_cpu_model ipa_cpu_model_inst (.clock(clock), .rst(rst), .en(en),
        .irq_signal(irq_signal), .ack_valid(ack_valid), .cpu_ack(cpu_ack));
    initial begin
        forever #20 clock = ~clock;
    end
    function automatic logic [7:0] impl(input logic [7:0] x);
        return x & (8'hff << (8 - PB));
    endfunction : impl
    function automatic logic [11:0] pa(input int i);
        return 12'h100 + 12'(4 * i);
    endfunction : pa
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // waitrequest is sampled at the rising edge, before the slave's flops move
    task automatic bus(input logic wr, input logic [11:0] a, input logic [7:0] w);
        @(posedge clock);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= {24'h0, w};
        do @(posedge clock); while (avs_waitrequest);
        d = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task automatic rd(input logic [11:0] a);
        bus(1'b0, a, 8'h00);
    endtask : rd
    task automatic sig(input logic e);
        @(negedge clock);
        chk({7'h0, irq_signal}, {7'h0, e});
    endtask : sig
    task automatic take(input logic [2:0] id);
        @(posedge clock);
        en <= 1'b1;
        repeat (20) begin
            @(negedge clock);
            if (ack_valid === 1'b1) break;
        end
        chk({5'h0, ack_id}, {5'h0, id});
        chk({7'h0, ack_spurious}, 8'h00);
        @(posedge clock);
        en <= 1'b0;
    endtask : take
    task automatic pulse(input logic drop, input logic [2:0] id);
        @(posedge clock);
        prio_drop <= drop;
        drop_id <= id;
        deactivate <= !drop;
        deact_id <= id;
        @(posedge clock);
        prio_drop <= 1'b0;
        deactivate <= 1'b0;
    endtask : pulse
    task automatic finish_test;
        if (n_errors == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test
    initial begin
        repeat (5000) @(posedge clock);
        n_errors++;
        finish_test();
    end
    initial begin
        void'($urandom(85));
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        rd(ipa_pkg::OFS_MASK);
        chk(d, ipa_pkg::MASK_RESET);
        irq_pending <= 8'h01;
        rd(ipa_pkg::OFS_RUNPRIO);
        chk(d, ipa_pkg::RUN_IDLE);
        sig(1'b0);
        @(posedge clock);
        irq_pending <= 8'h00;
        bus(1'b1, pa(0), ipa_pkg::PRIO_FIELD_ONES);
        rd(pa(0));
        chk(d, impl(8'hff));
        bus(1'b1, pa(7), 8'h00);
        rd(pa(7));
        chk(d, 8'h10);
        repeat (4) begin
            k = $urandom % 7;
            v = 8'($urandom);
            bus(1'b1, pa(k), v);
            rd(pa(k));
            chk(d, impl(v));
        end
        rd(12'h0f0);
        chk(d, 8'h00);
        irq_pending <= 8'h01;
        bus(1'b1, ipa_pkg::OFS_MASK, 8'hff);
        rd(ipa_pkg::OFS_MASK);
        chk(d, impl(8'hff));
        bus(1'b1, pa(0), 8'hff);
        sig(1'b0);
        bus(1'b1, pa(0), 8'h40);
        bus(1'b1, ipa_pkg::OFS_MASK, 8'h40);
        sig(1'b0);
        bus(1'b1, ipa_pkg::OFS_MASK, 8'h48);
        sig(1'b1);
        bus(1'b1, ipa_pkg::OFS_BINPT, 8'h07);
        rd(ipa_pkg::OFS_BINPT);
        chk(d, 8'h07);
        bus(1'b1, ipa_pkg::OFS_BINPT, 8'h03);
        bus(1'b1, ipa_pkg::OFS_MASK, 8'hff);
        bus(1'b1, pa(0), 8'h20);
        bus(1'b1, pa(1), 8'h28);
        bus(1'b1, pa(2), 8'h10);
        take(3'h0);
        rd(ipa_pkg::OFS_RUNPRIO);
        chk(d, 8'h20);
        irq_pending <= 8'h03;
        sig(1'b0);
        @(posedge clock);
        irq_pending <= 8'h07;
        sig(1'b1);
        take(3'h2);
        rd(ipa_pkg::OFS_PREEMPT);
        chk(d, 8'h01);
        rd(ipa_pkg::OFS_RUNPRIO);
        chk(d, 8'h10);
        pulse(1'b1, 3'h2);
        rd(ipa_pkg::OFS_RUNPRIO);
        chk(d, 8'h20);
        pulse(1'b0, 3'h0);
        rd(ipa_pkg::OFS_RUNPRIO);
        chk(d, ipa_pkg::RUN_IDLE);
        rd(ipa_pkg::OFS_ACTIVE);
        chk(d, 8'h04);
        finish_test();
    end
endmodule : interrupt_priority_arbiter_tb
